// ---- orsq_pkg.sv ----
// Constants shared by the output ramp sequencer
package orsq_pkg;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [7:0] RAMP_RATE_CONFIG_ADDR = 8'h03;
	localparam logic [7:0] SHUTDOWN_DELAY_ADDR = 8'h06;
	localparam logic [7:0] RAMP_RATE_CONFIG_RESET = 8'h1c;
	localparam logic [7:0] SHUTDOWN_DELAY_RESET = 8'h0b;
	localparam logic [7:0] RAMP_RATE_CONFIG_MASK = 8'h7f;
	localparam logic [7:0] SHUTDOWN_DELAY_MASK = 8'h3f;

	// Field positions in ramp_rate_config
	localparam int RISE_RATE_LSB = 4;
	localparam int FALLING_RAMP_ENABLE_BIT = 3;
	localparam int FALL_RATE_LSB = 0;
	localparam logic [2:0] RISE_RATE_DEFAULT = 3'h1;
	localparam logic [2:0] FALL_RATE_DEFAULT = 3'h4;
	localparam logic [2:0] RATE_RESERVED = 3'h7;

	// ----------------------------------------
	// Timing, in master clock ticks
	// ----------------------------------------
	localparam int MASTER_TICKS_PER_MS = 1000;
	localparam int STEP_MV = 10;
	localparam logic [11:0] STEP_LSB = 12'h004;
	localparam int WAIT_W = 20;
	localparam int STEP_W = 8;

	// Load-line scale: code * amps(1/8 A) * 57 / 1024 in 2.5 mV units
	localparam logic [6:0] DROOP_SCALE = 7'h39;
	localparam int DROOP_SHIFT = 10;

	// Rate codes in mV/ms
	function automatic logic [STEP_W-1:0] rate_ticks(input int mv_per_ms);
		rate_ticks = STEP_W'(STEP_MV * MASTER_TICKS_PER_MS / mv_per_ms);
	endfunction

	function automatic logic [STEP_W-1:0] rise_ticks_of(input logic [2:0] c);
		case (c)
			3'h2: rise_ticks_of = rate_ticks(200);
			3'h3: rise_ticks_of = rate_ticks(250);
			3'h4: rise_ticks_of = rate_ticks(500);
			3'h5: rise_ticks_of = rate_ticks(1000);
			3'h6: rise_ticks_of = rate_ticks(2000);
			default: rise_ticks_of = rate_ticks(100);
		endcase
	endfunction

	function automatic logic [STEP_W-1:0] fall_ticks_of(input logic [2:0] c);
		case (c)
			3'h0: fall_ticks_of = rate_ticks(50);
			3'h1: fall_ticks_of = rate_ticks(100);
			3'h2: fall_ticks_of = rate_ticks(200);
			3'h3: fall_ticks_of = rate_ticks(250);
			3'h5: fall_ticks_of = rate_ticks(1000);
			3'h6: fall_ticks_of = rate_ticks(2000);
			default: fall_ticks_of = rate_ticks(500);
		endcase
	endfunction

	typedef enum logic [2:0] {
		ST_OFF,
		ST_ON_WAIT,
		ST_RAMP_UP,
		ST_ON,
		ST_OFF_WAIT,
		ST_RAMP_DOWN
	} orsq_state_t;

endpackage

// ---- orsq_down_counter.sv ----
// Loadable down counter stepped by master clock ticks
`timescale 1ns/10ps
`default_nettype none
module orsq_down_counter #(
	parameter int W = 8
) (
	// Clock and reset
	input wire logic clock_i,
	input wire logic rst_n_i,
	// Control
	input wire logic load_i,
	input wire logic [W-1:0] load_val_i,
	input wire logic dec_i,
	// Status
	output logic zero_o
);
	logic [W-1:0] count_reg;

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			count_reg <= '0;
		end else if (load_i) begin
			count_reg <= load_val_i;
		end else if (dec_i && count_reg != '0) begin
			count_reg <= count_reg - W'(1);
		end
	end

	assign zero_o = (count_reg == '0);
endmodule
`default_nettype wire

// ---- orsq_sequencer.sv ----
// Turn-on/turn-off sequencing, ramp control and load-line positioning
`timescale 1ns/10ps
`default_nettype none
module orsq_sequencer
	import orsq_pkg::*;
(
	// Clock and reset
	input wire logic clock_i,
	input wire logic rst_n_i,
	// Register port
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [7:0] reg_rdata_o,
	// Commands and timing
	input wire logic turn_on_i,
	input wire logic turn_off_i,
	input wire logic master_tick_i,
	input wire logic [7:0] startup_delay_i,
	// Regulation inputs
	input wire logic [11:0] setpoint_i,
	input wire logic [2:0] load_line_sel_i,
	input wire logic [7:0] load_current_i,
	input wire logic [7:0] overcurrent_threshold_i,
	// Power stage
	output logic [11:0] ref_o,
	output logic high_side_en_o,
	output logic low_side_en_o,
	output logic ocp_fault_o,
	output logic ramping_o
);
	import orsq_pkg::*;

	// ----------------------------------------
	// Reset release
	// ----------------------------------------
	logic rst_meta_reg;
	logic rst_sync_reg;
	logic rst_n;

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_sync_reg <= rst_meta_reg;
		end
	end
	assign rst_n = rst_sync_reg;

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [7:0] ramp_rate_config_reg;
	logic [7:0] shutdown_delay_reg;
	wire wr_rate = reg_wr_i && (reg_addr_i == RAMP_RATE_CONFIG_ADDR);
	wire wr_delay = reg_wr_i && (reg_addr_i == SHUTDOWN_DELAY_ADDR);
	logic [7:0] rdata_next;

	always_comb begin
		if (reg_addr_i == RAMP_RATE_CONFIG_ADDR) begin
			rdata_next = ramp_rate_config_reg;
		end else if (reg_addr_i == SHUTDOWN_DELAY_ADDR) begin
			rdata_next = shutdown_delay_reg;
		end else begin
			rdata_next = 8'h00;
		end
	end

	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			ramp_rate_config_reg <= RAMP_RATE_CONFIG_RESET;
			shutdown_delay_reg <= SHUTDOWN_DELAY_RESET;
			reg_rdata_o <= 8'h00;
		end else begin
			if (wr_rate)
				ramp_rate_config_reg <= reg_wdata_i & RAMP_RATE_CONFIG_MASK;
			if (wr_delay)
				shutdown_delay_reg <= reg_wdata_i & SHUTDOWN_DELAY_MASK;
			if (reg_rd_i)
				reg_rdata_o <= rdata_next;
		end
	end

	// ----------------------------------------
	// Rate decode
	// ----------------------------------------
	wire [2:0] rise_code = ramp_rate_config_reg[RISE_RATE_LSB +: 3];
	wire [2:0] fall_code = ramp_rate_config_reg[FALL_RATE_LSB +: 3];
	wire fall_enable = ramp_rate_config_reg[FALLING_RAMP_ENABLE_BIT];
	// Reserved codes fall back to the reset rate rather than stalling
	wire [STEP_W-1:0] rise_ticks = rise_ticks_of(rise_code);
	wire [STEP_W-1:0] fall_ticks = fall_ticks_of(fall_code);

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	orsq_state_t state_reg;
	logic [11:0] ramp_ref_reg;
	logic fall_en_reg;
	logic wait_zero;
	logic step_zero;

	wire [WAIT_W-1:0] on_full = WAIT_W'(startup_delay_i) * WAIT_W'(MASTER_TICKS_PER_MS);
	wire [WAIT_W-1:0] off_full = WAIT_W'(shutdown_delay_reg[5:0]) * WAIT_W'(MASTER_TICKS_PER_MS);
	wire [10:0] down_steps = 11'((13'(ramp_ref_reg) + 13'd3) >> 2);
	wire [WAIT_W-1:0] down_ticks = WAIT_W'(down_steps) * WAIT_W'(fall_ticks);
	// Manager must keep the delay above the ramp time; clamp if not
	wire [WAIT_W-1:0] off_wait = (off_full > down_ticks) ?
		off_full - down_ticks : '0;
	wire [WAIT_W-1:0] off_load = fall_enable ? off_wait : off_full;

	wire running = (state_reg != ST_OFF);
	wire on_take = (state_reg == ST_OFF) && turn_on_i;
	wire off_take = running && (state_reg != ST_OFF_WAIT) &&
		(state_reg != ST_RAMP_DOWN) && turn_off_i;
	wire ocp_hit = (state_reg == ST_RAMP_UP) &&
		(load_current_i >= overcurrent_threshold_i);
	wire in_ramp = (state_reg == ST_RAMP_UP) || (state_reg == ST_RAMP_DOWN);
	wire step_due = in_ramp && step_zero;
	wire [12:0] up_sum = 13'(ramp_ref_reg) + 13'(STEP_LSB);
	wire up_last = (up_sum >= 13'(setpoint_i));
	wire down_last = (ramp_ref_reg <= STEP_LSB);
	wire wait_load = on_take || off_take;
	wire [WAIT_W-1:0] wait_val = on_take ? on_full : off_load;
	wire step_load = step_due || (state_reg == ST_ON_WAIT) ||
		(state_reg == ST_OFF_WAIT);
	wire [STEP_W-1:0] step_val = ((state_reg == ST_ON_WAIT) ||
		(state_reg == ST_RAMP_UP)) ? rise_ticks : fall_ticks;

	orsq_down_counter #(.W(WAIT_W)) u_wait (
		.clock_i(clock_i),
		.rst_n_i(rst_n),
		.load_i(wait_load),
		.load_val_i(wait_val),
		.dec_i(master_tick_i),
		.zero_o(wait_zero)
	);

	// Step time counted in master ticks so all converters match
	orsq_down_counter #(.W(STEP_W)) u_step (
		.clock_i(clock_i),
		.rst_n_i(rst_n),
		.load_i(step_load),
		.load_val_i(step_val),
		.dec_i(master_tick_i),
		.zero_o(step_zero)
	);

	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= ST_OFF;
			ramp_ref_reg <= 12'h000;
			fall_en_reg <= 1'b0;
			ocp_fault_o <= 1'b0;
		end else begin
			case (state_reg)
				ST_OFF: begin
					if (turn_on_i) begin
						state_reg <= ST_ON_WAIT;
						ocp_fault_o <= 1'b0;
					end
				end
				ST_ON_WAIT: begin
					if (wait_zero)
						state_reg <= ST_RAMP_UP;
				end
				ST_RAMP_UP: begin
					if (ocp_hit) begin
						state_reg <= ST_OFF;
						ramp_ref_reg <= 12'h000;
						ocp_fault_o <= 1'b1;
					end else if (step_due) begin
						if (up_last) begin
							ramp_ref_reg <= setpoint_i;
							state_reg <= ST_ON;
						end else begin
							ramp_ref_reg <= up_sum[11:0];
						end
					end
				end
				ST_ON: begin
					ramp_ref_reg <= setpoint_i;
				end
				ST_OFF_WAIT: begin
					if (wait_zero && fall_en_reg) begin
						state_reg <= ST_RAMP_DOWN;
					end else if (wait_zero) begin
						state_reg <= ST_OFF;
						ramp_ref_reg <= 12'h000;
					end
				end
				ST_RAMP_DOWN: begin
					if (step_due && down_last) begin
						ramp_ref_reg <= 12'h000;
						state_reg <= ST_OFF;
					end else if (step_due) begin
						ramp_ref_reg <= ramp_ref_reg - STEP_LSB;
					end
				end
				default: state_reg <= ST_OFF;
			endcase
			if (off_take && !ocp_hit) begin
				state_reg <= ST_OFF_WAIT;
				fall_en_reg <= fall_enable;
			end
		end
	end

	// ----------------------------------------
	// Load-line positioning and outputs
	// ----------------------------------------
	wire [16:0] droop_prod = 17'(load_line_sel_i) * 17'(load_current_i) *
		17'(DROOP_SCALE);
	wire [11:0] droop = 12'(droop_prod >> DROOP_SHIFT);
	wire [11:0] ref_next = (ramp_ref_reg > droop) ?
		ramp_ref_reg - droop : 12'h000;

	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			ref_o <= 12'h000;
			high_side_en_o <= 1'b0;
			low_side_en_o <= 1'b0;
			ramping_o <= 1'b0;
		end else begin
			ref_o <= running ? ref_next : 12'h000;
			high_side_en_o <= running;
			low_side_en_o <= running;
			ramping_o <= in_ramp;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rst_n);

	property p_on_delay;
		(state_reg == ST_ON_WAIT) && !wait_zero && !turn_off_i |=>
			state_reg != ST_RAMP_UP;
	endproperty
	a_on_delay: assert property (p_on_delay) else $error("ramp before delay");

	property p_off_ramp;
		(state_reg == ST_OFF_WAIT) && wait_zero && fall_en_reg |=>
			state_reg == ST_RAMP_DOWN;
	endproperty
	a_off_ramp: assert property (p_off_ramp) else $error("no ramp-down");

	property p_off_wait_calc;
		off_take && fall_enable |-> (off_load == '0) ||
			(off_load + down_ticks == off_full);
	endproperty
	a_off_wait_calc: assert property (p_off_wait_calc) else $error("bad wait");

	property p_hard_off;
		(state_reg == ST_OFF_WAIT) && wait_zero && !fall_en_reg |=>
			##1 !high_side_en_o && !low_side_en_o;
	endproperty
	a_hard_off: assert property (p_hard_off) else $error("switches stay on");

	property p_delay_upper;
		reg_rd_i && reg_addr_i == SHUTDOWN_DELAY_ADDR |=> reg_rdata_o[7:6] == 2'b00;
	endproperty
	a_delay_upper: assert property (p_delay_upper) else $error("upper bits set");

	property p_rate_upper;
		ramp_rate_config_reg[7] == 1'b0;
	endproperty
	a_rate_upper: assert property (p_rate_upper) else $error("bit 7 set");

	property p_step_size;
		step_due && (state_reg == ST_RAMP_UP) && !up_last && !ocp_hit &&
			!turn_off_i |=> ramp_ref_reg == $past(ramp_ref_reg) + STEP_LSB;
	endproperty
	a_step_size: assert property (p_step_size) else $error("step not 10 mV");

	property p_step_hold;
		(state_reg == ST_RAMP_UP) && !step_zero && !ocp_hit |=>
			$stable(ramp_ref_reg);
	endproperty
	a_step_hold: assert property (p_step_hold) else $error("step early");

	property p_rise_code;
		rise_code == 3'h5 |-> rise_ticks == 8'h0a;
	endproperty
	a_rise_code: assert property (p_rise_code) else $error("rise table");

	property p_fall_code;
		fall_code == 3'h0 |-> fall_ticks == 8'hc8;
	endproperty
	a_fall_code: assert property (p_fall_code) else $error("fall table");

	property p_ocp;
		ocp_hit |=> ocp_fault_o ##1 !high_side_en_o;
	endproperty
	a_ocp: assert property (p_ocp) else $error("no trip");

	property p_droop;
		running && (ramp_ref_reg > droop) |=> ref_o == $past(ramp_ref_reg - droop);
	endproperty
	a_droop: assert property (p_droop) else $error("bad droop");

	c_start: cover property (state_reg == ST_RAMP_UP ##[1:300] state_reg == ST_ON);
	c_soft_off: cover property (state_reg == ST_RAMP_DOWN ##1 state_reg == ST_OFF);
	c_trip: cover property (ocp_hit);
endmodule
`default_nettype wire

// ---- orsq_power_manager.sv ----
// Power manager model: master clock tick source
`timescale 1ns/10ps
`default_nettype none
module orsq_power_manager (
	// Clock
	input wire logic clock_i,
	// Control
	input wire logic tick_en_i,
	// Master clock
	output logic master_tick_o
);
	// ----------------------------------------
	// Master tick
	// ----------------------------------------
	// One tick a cycle keeps a millisecond at 1000 cycles
	always_ff @(posedge clock_i) begin
		master_tick_o <= tick_en_i;
	end
endmodule
`default_nettype wire

// ---- orsq_sequencer_tb.sv ----
// Self-checking bench for the output ramp sequencer
`timescale 1ns/10ps
`default_nettype none
module orsq_sequencer_tb;
	import orsq_pkg::*;
	logic clock_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic [7:0] rdata;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic on = 1'b0;
	logic off = 1'b0;
	logic tick_en = 1'b0;
	logic tick;
	logic [7:0] sdel = 8'h01;
	logic [7:0] cur = 8'h00;
	logic [7:0] thr = 8'hff;
	logic [11:0] setp = 12'h190;
	logic [2:0] ll = 3'h0;
	logic [11:0] ref_v;
	logic hs, ls, ocp, ramping;
	int num_errors = 0;
	int n_compared = 0;

	always #20 clock_i = ~clock_i;

	orsq_power_manager pm_u (
		.clock_i(clock_i),
		.tick_en_i(tick_en),
		.master_tick_o(tick)
	);

	orsq_sequencer dut_u (
		.clock_i(clock_i),
		.rst_n_i(rst_n_i),
		.reg_addr_i(addr),
		.reg_wdata_i(wdata),
		.reg_wr_i(wr),
		.reg_rd_i(rd),
		.reg_rdata_o(rdata),
		.turn_on_i(on),
		.turn_off_i(off),
		.master_tick_i(tick),
		.startup_delay_i(sdel),
		.setpoint_i(setp),
		.load_line_sel_i(ll),
		.load_current_i(cur),
		.overcurrent_threshold_i(thr),
		.ref_o(ref_v),
		.high_side_en_o(hs),
		.low_side_en_o(ls),
		.ocp_fault_o(ocp),
		.ramping_o(ramping)
	);

	// ----------------------------------------
	// Bench tasks
	// ----------------------------------------
	task automatic wrap_up();
		if (num_errors == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clock_i);
		#1;
	endtask

	// Strobe drops one cycle before the next access may raise it
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		addr = a;
		wdata = d;
		wr = 1'b1;
		cyc(1);
		wr = 1'b0;
		cyc(1);
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		addr = a;
		rd = 1'b1;
		cyc(1);
		rd = 1'b0;
		cyc(1);
		chk(12'(rdata), 12'(exp));
	endtask

	task automatic cmd(input logic is_on);
		if (is_on)
			on = 1'b1;
		else
			off = 1'b1;
		cyc(1);
		on = 1'b0;
		off = 1'b0;
		cyc(1);
	endtask

	task automatic wait_ref(input logic [11:0] v, input int lim);
		int i;
		for (i = 0; i < lim && ref_v !== v; i++)
			cyc(1);
		if (ref_v !== v) begin
			num_errors++;
			wrap_up();
		end
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		cyc(2);
		rst_n_i = 1'b1;
		cyc(4);
		tick_en = 1'b1;
		rd_chk(RAMP_RATE_CONFIG_ADDR, 8'h1c);
		rd_chk(SHUTDOWN_DELAY_ADDR, 8'h0b);
		wr_reg(SHUTDOWN_DELAY_ADDR, 8'hff);
		rd_chk(SHUTDOWN_DELAY_ADDR, 8'h3f);
		wr_reg(RAMP_RATE_CONFIG_ADDR, 8'hff);
		rd_chk(RAMP_RATE_CONFIG_ADDR, 8'h7f);
		wr_reg(8'h05, 8'h5a);
		rd_chk(8'h05, 8'h00);
		// Rise code 5 and fall code 0 reach the rate table checks
		wr_reg(RAMP_RATE_CONFIG_ADDR, 8'h58);
		rd_chk(RAMP_RATE_CONFIG_ADDR, 8'h58);
		// Fastest rates; 1 ms delay leaves 500 ticks before ramp-down
		wr_reg(RAMP_RATE_CONFIG_ADDR, 8'h6e);
		wr_reg(SHUTDOWN_DELAY_ADDR, 8'h01);
		cmd(1'b1);
		cyc(900);
		chk(ref_v, 12'h000);
		chk(12'(hs), 12'h001);
		wait_ref(12'h004, 300);
		chk(12'(ramping), 12'h001);
		tick_en = 1'b0;
		cyc(20);
		chk(ref_v, 12'h004);
		tick_en = 1'b1;
		wait_ref(12'h190, 800);
		chk(12'(ramping), 12'h000);
		for (int k = 0; k < 8; k++) begin
			ll = 3'(k);
			cur = 8'h80;
			cyc(4);
			chk(ref_v, 12'(400 - ((k * 128 * 57) >> 10)));
		end
		ll = 3'h0;
		cur = 8'h00;
		cyc(4);
		cmd(1'b0);
		cyc(400);
		chk(ref_v, 12'h190);
		chk(12'(ramping), 12'h000);
		// Wait of 500 ticks is over well before the full delay
		cyc(120);
		chk(12'(ramping), 12'h001);
		wait_ref(12'h000, 780);
		cyc(3);
		chk(12'({hs, ls}), 12'h000);
		// Falling ramp off: switches stop when the delay ends
		wr_reg(RAMP_RATE_CONFIG_ADDR, 8'h66);
		cmd(1'b1);
		wait_ref(12'h190, 2000);
		cmd(1'b0);
		cyc(900);
		chk(12'(hs), 12'h001);
		cyc(150);
		chk(12'({hs, ls}), 12'h000);
		chk(ref_v, 12'h000);
		// Load above threshold while ramping up
		thr = 8'h10;
		cur = 8'h20;
		cmd(1'b1);
		cyc(1100);
		chk(12'(ocp), 12'h001);
		chk(12'(hs), 12'h000);
		// Threshold raised clear of the load current
		thr = 8'hff;
		cur = 8'h00;
		cmd(1'b1);
		cyc(3);
		chk(12'(ocp), 12'h000);
		// Reset in mid-run restores the register defaults
		rst_n_i = 1'b0;
		cyc(2);
		chk(12'({hs, ls}), 12'h000);
		rst_n_i = 1'b1;
		cyc(4);
		rd_chk(RAMP_RATE_CONFIG_ADDR, 8'h1c);
		rd_chk(SHUTDOWN_DELAY_ADDR, 8'h0b);
		// Single converter, so no parallel group is needed
		wrap_up();
	end
endmodule
`default_nettype wire
